// ==== core/clk_cfg_pkg.sv ====
// package of constants and types for the dpll and apll configuration block
// ----------------------------------------------------------------------------
// Overview of operation
// - phase offset shifts dpll output by up to 200 ns in 6 ps steps; the 16-bit field stops at +/-32767 steps
// - offset enters via feedback path, output slews at a bandwidth-set rate
// - offset written in free-run or hold takes effect only once locking
// - while locked, measured frequency shows the integral path value
// - frequency measurement is referenced to master clock plus trim offset
// - measured phase field reports input to feedback difference, low-pass averaged
// - apparent frequency offset beyond hard limits marks the input invalid
// - wide tracking doubles lsb weight of limits, hold and measured frequency
// - wide tracking doubles bandwidths and scales damping by root two
// - selector 0xx locks each apll to crystal, oscillator, input one or two
// - pin select enable picks field or pin; pin high picks alternate selector
// - selector 1xx locks apll1 to dpll synth, apll2 to crystal
// - synth selector not 1111 gives presets, 1111 gives programmable 2 kHz grid
// - each apll runs only while its enable bit is one
// - high-speed divider divides vco by its value, 50 percent duty for even values only
// - feedback ratio is integer part plus remainder over denominator, scaled
// - after feedback writes, enable toggled 0 to 1 makes apll relock
// - in hold the dpll tracks nothing and uses hold frequency, zero is free-run
// ----------------------------------------------------------------------------
package clk_cfg_pkg;
   // ------------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------------
   localparam int OFFSET_W     = 16;   // +/-200 ns / 6 ps is +/-33333, beyond 16 bits signed (+/-32767)
   localparam int MEASURED_FIELD_A_W       = 32;
   localparam int PHASE_W      = 10;
   localparam int SEL_W        = 3;
   localparam int DFS_W        = 4;
   localparam int HIGH_SPEED_DIVIDER_W      = 6;
   localparam int FBDIV_W      = 75;   // 9 integer bits plus up to 66 fraction bits
   localparam int FBREM_W      = 32;
   localparam int FBDEN_W      = 32;
   localparam int FBBP_W       = 7;
   localparam int SLEW_SHIFT   = 4;    // offset slew step = remainder >> (shift - bw / 4)
   localparam int PHASE_AVG_SH = 4;    // averaging shift for measured phase
   localparam int DIFF_W       = MEASURED_FIELD_A_W + 1;
   // ------------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------------
   localparam logic [FBBP_W-1:0]  FBBP_RESET   = 7'h2A;  // 42
   localparam logic [HIGH_SPEED_DIVIDER_W-1:0] HIGH_SPEED_DIVIDER_RESET  = 6'h06;
   localparam logic [DFS_W-1:0]   DFS_PROG     = 4'hF;
   localparam logic [SEL_W-1:0]   SEL_DPLL     = 3'h4;
   localparam logic [1:0]         SRC_XTAL     = 2'h0;
   localparam logic [1:0]         SRC_MCLK     = 2'h1;
   localparam logic [1:0]         SRC_IC1      = 2'h2;
   localparam logic [1:0]         SRC_IC2      = 2'h3;
   // apll1 input code: source in low bits, dpll synth when bit 2 set
   typedef enum logic [3:0] {
      DPLL_FREE   = 4'b0001,
      DPLL_HOLD   = 4'b0010,
      DPLL_ACQ    = 4'b0100,
      DPLL_LOCKED = 4'b1000
   } dpll_state_t;
endpackage

// ==== core/hs_divider.sv ====
// high-speed divider with 50 percent duty for even values, high for ceil(n/2) of n counts for odd values
`timescale 1ns/1ps
module hs_divider #(
   parameter int W = 6
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_div,
   output logic              o_clk_div
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         rise_half;
      logic         fall_half;
   } st_t;
   st_t s_q, s_d;
   logic [W-1:0] half_hi;
   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // odd values: output is or of a rise-edge half and a delayed copy,
   // built here in one clock as high for ceil(n/2) counts per period
   always_comb begin
      s_d = s_q;
      half_hi = W'(({1'b0, i_div} + (W+1)'(1)) >> 1);
      if (!i_run || i_div < W'(2)) begin
         s_d.cnt = '0;
         s_d.rise_half = i_run && i_div == W'(1);
         s_d.fall_half = 1'b0;
      end else begin
         s_d.cnt = (s_q.cnt >= i_div - W'(1)) ? '0 : s_q.cnt + W'(1);
         s_d.rise_half = s_d.cnt < (i_div >> 1);
         s_d.fall_half = i_div[0] && s_d.cnt == (i_div >> 1);
      end
      if (half_hi == '0) s_d.fall_half = 1'b0;
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) s_q <= '0;
      else s_q <= s_d;
   end
   // the fall_half slot stands in for the half-cycle extension an odd
   // divider needs; in silicon it is a negative-edge flop on the vco
   assign o_clk_div = s_q.rise_half | s_q.fall_half;

   property p_div_run;
      @(posedge i_sys_clk) disable iff (!i_reset_n) !i_run |=> !o_clk_div;
   endproperty
   a_div_run: assert property (p_div_run) else $error("divider output while stopped");
endmodule

// ==== core/dpll_apll_measured_field_a_config.sv ====
// dpll phase, measurement and tracking controls plus apll source and divider config
`timescale 1ns/1ps
module dpll_apll_measured_field_a_config #(
   parameter int OFFSET_W = clk_cfg_pkg::OFFSET_W,
   parameter int MEASURED_FIELD_A_W   = clk_cfg_pkg::MEASURED_FIELD_A_W
) (
   input  wire logic                                i_sys_clk,
   input  wire logic                                i_reset_n,
   // dpll side
   input  wire logic signed [OFFSET_W-1:0]          i_phase_offset,
   input  wire logic [2:0]                          i_dpll_state_req,
   input  wire logic [3:0]                          i_locked_bandwidth,
   input  wire logic [3:0]                          i_acquire_bandwidth,
   input  wire logic [2:0]                          i_locked_damping,
   input  wire logic [2:0]                          i_acquire_damping,
   input  wire logic                                i_wide_tracking_enable,
   input  wire logic signed [MEASURED_FIELD_A_W-1:0]            i_integral_path,
   input  wire logic signed [MEASURED_FIELD_A_W-1:0]            i_master_clock_measured_field_a_trim,
   input  wire logic signed [MEASURED_FIELD_A_W-1:0]            i_hold_measured_field_a_value,
   input  wire logic [MEASURED_FIELD_A_W-1:0]                   i_hard_measured_field_a_limit,
   input  wire logic [MEASURED_FIELD_A_W-1:0]                   i_soft_measured_field_a_limit,
   input  wire logic [MEASURED_FIELD_A_W-1:0]                   i_input_measured_field_a_hard_limits,
   input  wire logic signed [MEASURED_FIELD_A_W-1:0]            i_input_measured_field_a_offset,
   input  wire logic signed [clk_cfg_pkg::PHASE_W-1:0] i_phase_diff,
   output logic signed [OFFSET_W-1:0]               o_applied_offset,
   output logic signed [MEASURED_FIELD_A_W:0]                   o_measured_field_a,
   output logic signed [clk_cfg_pkg::PHASE_W-1:0]   o_measured_phase,
   output logic signed [MEASURED_FIELD_A_W:0]                   o_nco_measured_field_a,
   output logic                                     o_input_invalid,
   output logic                                     o_hard_limit_hit,
   output logic                                     o_soft_limit_hit,
   output logic [4:0]                               o_eff_bandwidth,
   output logic [3:0]                               o_eff_damping_x2,
   output logic [3:0]                               o_dpll_state,
   // apll side
   input  wire logic                                i_ext_switch_pin,
   input  wire logic                                i_pin_select_enable,
   input  wire logic [clk_cfg_pkg::SEL_W-1:0]       i_apll_source_selector,
   input  wire logic [clk_cfg_pkg::SEL_W-1:0]       i_apll_alternate_selector,
   input  wire logic [1:0]                          i_apll_input_divider,
   input  wire logic [clk_cfg_pkg::DFS_W-1:0]       i_synth_measured_field_a_selector,
   input  wire logic [15:0]                         i_synth_prog_mult,
   input  wire logic [1:0]                          i_apll_enable_bit,
   input  wire logic [clk_cfg_pkg::HIGH_SPEED_DIVIDER_W-1:0]     i_high_speed_divider,
   input  wire logic [clk_cfg_pkg::FBDIV_W-1:0]     i_fb_integer_part,
   input  wire logic [clk_cfg_pkg::FBREM_W-1:0]     i_fb_remainder,
   input  wire logic [clk_cfg_pkg::FBDEN_W-1:0]     i_fb_denominator,
   input  wire logic [clk_cfg_pkg::FBBP_W-1:0]      i_fb_binary_point,
   output logic [2:0]                               o_apll1_source,
   output logic [2:0]                               o_apll2_source,
   output logic [1:0]                               o_apll_input_divider,
   output logic                                     o_synth_programmable,
   output logic [3:0]                               o_synth_preset,
   output logic [15:0]                              o_synth_mult_2khz,
   output logic [1:0]                               o_apll_run,
   output logic [1:0]                               o_apll_relock,
   output logic [clk_cfg_pkg::FBDIV_W-1:0]          o_fb_integer_active,
   output logic [clk_cfg_pkg::FBREM_W-1:0]          o_fb_remainder_active,
   output logic [clk_cfg_pkg::FBDEN_W-1:0]          o_fb_denominator_active,
   output logic [clk_cfg_pkg::FBBP_W-1:0]           o_fb_binary_point_active,
   output logic                                     o_hs_clk
);
   localparam int PW = clk_cfg_pkg::PHASE_W;
   localparam int DW = clk_cfg_pkg::DIFF_W;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      clk_cfg_pkg::dpll_state_t           state;
      logic signed [OFFSET_W-1:0]         applied;
      logic signed [OFFSET_W-1:0]         target;
      logic signed [DW-1:0]               meas;
      logic signed [PW+clk_cfg_pkg::PHASE_AVG_SH-1:0] phase_acc;
      logic signed [DW-1:0]               nco;
      logic                               invalid;
      logic                               hard_hit;
      logic                               soft_hit;
      logic [4:0]                         bw;
      logic [3:0]                         damp;
      logic                               sw_meta;
      logic                               sw_sync;
      logic [2:0]                         src1;
      logic [2:0]                         src2;
      logic [1:0]                         idiv;
      logic                               prog;
      logic [3:0]                         preset;
      logic [15:0]                        mult;
      logic [1:0]                         en_prev;
      logic [1:0]                         relock;
      logic [clk_cfg_pkg::FBDIV_W-1:0]    fb_int;
      logic [clk_cfg_pkg::FBREM_W-1:0]    fb_rem;
      logic [clk_cfg_pkg::FBDEN_W-1:0]    fb_den;
      logic [clk_cfg_pkg::FBBP_W-1:0]     fb_bp;
   } st_t;
   st_t s_q, s_d;

   // scale a frequency field by the tracking mode
   function automatic logic signed [DW-1:0] scale_f(input logic signed [MEASURED_FIELD_A_W-1:0] v, input logic wide);
      scale_f = wide ? {v, 1'b0} : {v[MEASURED_FIELD_A_W-1], v};
   endfunction

   function automatic logic signed [DW-1:0] mag(input logic signed [DW-1:0] v);
      mag = v[DW-1] ? -v : v;
   endfunction

   logic signed [DW-1:0] meas_scaled;
   logic signed [DW-1:0] ref_corr;
   logic signed [DW-1:0] hard_s;
   logic signed [DW-1:0] soft_s;
   logic signed [DW-1:0] in_lim_s;
   logic signed [OFFSET_W-1:0] step;
   logic signed [OFFSET_W-1:0] gap;
   logic [2:0] sel;
   logic locking;
   logic [3:0] bw_raw;
   logic [2:0] damp_raw;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // state follows the sequencer request
      case (i_dpll_state_req)
         3'h0: s_d.state = clk_cfg_pkg::DPLL_FREE;
         3'h1: s_d.state = clk_cfg_pkg::DPLL_HOLD;
         3'h2: s_d.state = clk_cfg_pkg::DPLL_ACQ;
         3'h3: s_d.state = clk_cfg_pkg::DPLL_LOCKED;
         default: s_d.state = clk_cfg_pkg::DPLL_FREE;
      endcase
      locking = s_q.state == clk_cfg_pkg::DPLL_ACQ || s_q.state == clk_cfg_pkg::DPLL_LOCKED;

      // effective bandwidth and damping, doubled / root-two in wide mode
      bw_raw   = (s_q.state == clk_cfg_pkg::DPLL_LOCKED) ? i_locked_bandwidth : i_acquire_bandwidth;
      damp_raw = (s_q.state == clk_cfg_pkg::DPLL_LOCKED) ? i_locked_damping : i_acquire_damping;
      s_d.bw   = i_wide_tracking_enable ? {bw_raw, 1'b0} : {1'b0, bw_raw};
      // damping code in half-octave steps: +1 step is a factor of root two
      s_d.damp = {1'b0, damp_raw} + {3'h0, i_wide_tracking_enable};

      // offset only latched as target while locking; slews in gradually
      if (locking) s_d.target = i_phase_offset;
      gap  = s_q.target - s_q.applied;
      step = gap >>> (clk_cfg_pkg::SLEW_SHIFT - int'(s_d.bw[4:2]));
      if (step == '0 && gap != '0) step = gap[OFFSET_W-1] ? -OFFSET_W'(1) : OFFSET_W'(1);
      if (locking) s_d.applied = s_q.applied + step;

      // measured frequency vs corrected master reference
      ref_corr    = scale_f(i_master_clock_measured_field_a_trim, i_wide_tracking_enable);
      meas_scaled = scale_f(i_integral_path, i_wide_tracking_enable);
      if (s_q.state == clk_cfg_pkg::DPLL_LOCKED) s_d.meas = meas_scaled + ref_corr;

      // nco word: hold frequency in hold, zero is free-run
      case (s_q.state)
         clk_cfg_pkg::DPLL_HOLD: s_d.nco = scale_f(i_hold_measured_field_a_value, i_wide_tracking_enable);
         clk_cfg_pkg::DPLL_FREE: s_d.nco = '0;
         default:                s_d.nco = meas_scaled;
      endcase

      // limits scaled with the lsb weight
      hard_s     = scale_f(i_hard_measured_field_a_limit, i_wide_tracking_enable);
      soft_s     = scale_f(i_soft_measured_field_a_limit, i_wide_tracking_enable);
      in_lim_s   = scale_f(i_input_measured_field_a_hard_limits, i_wide_tracking_enable);
      s_d.hard_hit = locking && mag(meas_scaled) >= hard_s;
      s_d.soft_hit = locking && mag(meas_scaled) > soft_s;
      s_d.invalid  = mag(scale_f(i_input_measured_field_a_offset, i_wide_tracking_enable)) > in_lim_s;

      // phase averaging: one-pole filter approximating the 100 Hz corner
      s_d.phase_acc = s_q.phase_acc + (PW+clk_cfg_pkg::PHASE_AVG_SH)'(i_phase_diff)
                    - (s_q.phase_acc >>> clk_cfg_pkg::PHASE_AVG_SH);

      // synchronised switch pin picks primary or alternate selector
      s_d.sw_meta = i_ext_switch_pin;
      s_d.sw_sync = s_q.sw_meta;
      sel = (i_pin_select_enable && s_q.sw_sync) ? i_apll_alternate_selector
                                                 : i_apll_source_selector;
      if (sel[2]) begin
         s_d.src1 = clk_cfg_pkg::SEL_DPLL;
         s_d.src2 = {1'b0, clk_cfg_pkg::SRC_XTAL};
      end else begin
         s_d.src1 = {1'b0, sel[1:0]};
         s_d.src2 = {1'b0, sel[1:0]};
      end
      s_d.idiv   = i_apll_input_divider;
      s_d.prog   = i_synth_measured_field_a_selector == clk_cfg_pkg::DFS_PROG;
      s_d.preset = s_d.prog ? 4'h0 : i_synth_measured_field_a_selector;
      s_d.mult   = s_d.prog ? i_synth_prog_mult : 16'h0000;

      // feedback fields captured on enable rise, relock pulse per apll
      s_d.en_prev = i_apll_enable_bit;
      s_d.relock  = i_apll_enable_bit & ~s_q.en_prev;
      if (|(i_apll_enable_bit & ~s_q.en_prev)) begin
         s_d.fb_int = i_fb_integer_part;
         s_d.fb_rem = i_fb_remainder;
         s_d.fb_den = i_fb_denominator;
         s_d.fb_bp  = i_fb_binary_point;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         s_q       <= '0;
         s_q.state <= clk_cfg_pkg::DPLL_FREE;
         s_q.fb_bp <= clk_cfg_pkg::FBBP_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign o_applied_offset         = s_q.applied;
   assign o_measured_field_a       = s_q.meas;
   assign o_measured_phase         = s_q.phase_acc[PW+clk_cfg_pkg::PHASE_AVG_SH-1:clk_cfg_pkg::PHASE_AVG_SH];
   assign o_nco_measured_field_a               = s_q.nco;
   assign o_input_invalid          = s_q.invalid;
   assign o_hard_limit_hit         = s_q.hard_hit;
   assign o_soft_limit_hit         = s_q.soft_hit;
   assign o_eff_bandwidth          = s_q.bw;
   assign o_eff_damping_x2         = s_q.damp;
   assign o_dpll_state             = s_q.state;
   assign o_apll1_source           = s_q.src1;
   assign o_apll2_source           = s_q.src2;
   assign o_apll_input_divider     = s_q.idiv;
   assign o_synth_programmable     = s_q.prog;
   assign o_synth_preset           = s_q.preset;
   assign o_synth_mult_2khz        = s_q.mult;
   assign o_apll_run               = s_q.en_prev;
   assign o_apll_relock            = s_q.relock;
   assign o_fb_integer_active      = s_q.fb_int;
   assign o_fb_remainder_active    = s_q.fb_rem;
   assign o_fb_denominator_active  = s_q.fb_den;
   assign o_fb_binary_point_active = s_q.fb_bp;

   // high-speed divider model on apll1
   hs_divider #(.W(clk_cfg_pkg::HIGH_SPEED_DIVIDER_W)) u_high_speed_divider (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_run     (s_q.en_prev[0]),
      .i_div     (i_high_speed_divider),
      .o_clk_div (o_hs_clk)
   );

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   sequence s_en_rise;
      !i_apll_enable_bit[0] ##1 i_apll_enable_bit[0];
   endsequence
   property p_relock;
      @(posedge i_sys_clk) disable iff (!i_reset_n) s_en_rise |=> o_apll_relock[0];
   endproperty
   a_relock: assert property (p_relock) else $error("no relock on enable rise");
   property p_capture;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_en_rise |=> o_fb_integer_active == $past(i_fb_integer_part);
   endproperty
   a_capture: assert property (p_capture) else $error("feedback not captured");
   property p_hold_fb;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (&i_apll_enable_bit && &s_q.en_prev) |=> $stable(o_fb_integer_active);
   endproperty
   a_hold_fb: assert property (p_hold_fb) else $error("ratio changed while enabled");
   property p_no_slew_free;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_dpll_state == clk_cfg_pkg::DPLL_FREE || o_dpll_state == clk_cfg_pkg::DPLL_HOLD) |=> $stable(o_applied_offset);
   endproperty
   a_no_slew_free: assert property (p_no_slew_free) else $error("offset moved outside locking");
   property p_dpll_mode;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_apll_source_selector == clk_cfg_pkg::SEL_DPLL && !i_pin_select_enable) |=> o_apll1_source == clk_cfg_pkg::SEL_DPLL;
   endproperty
   a_dpll_mode: assert property (p_dpll_mode) else $error("apll1 not on dpll");
   property p_pinsel;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (!i_pin_select_enable && !i_apll_source_selector[2]) |=> o_apll2_source[1:0] == $past(i_apll_source_selector[1:0]);
   endproperty
   a_pinsel: assert property (p_pinsel) else $error("selector field not used");
   property p_prog;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_synth_measured_field_a_selector == clk_cfg_pkg::DFS_PROG) |=> o_synth_programmable;
   endproperty
   a_prog: assert property (p_prog) else $error("programmable synth not selected");
   property p_run;
      @(posedge i_sys_clk) disable iff (!i_reset_n) !i_apll_enable_bit[1] |=> !o_apll_run[1];
   endproperty
   a_run: assert property (p_run) else $error("apll2 running while disabled");
   property p_free_nco;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_dpll_state == clk_cfg_pkg::DPLL_FREE |=> o_nco_measured_field_a == '0;
   endproperty
   a_free_nco: assert property (p_free_nco) else $error("free-run nco not zero");
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the dpll and apll configuration block
`timescale 1ns/1ps
module testbench;
   logic i_sys_clk, i_reset_n, i_wide_tracking_enable, i_ext_switch_pin, i_pin_select_enable, o_input_invalid;
   logic o_hard_limit_hit, o_soft_limit_hit, o_synth_programmable, o_hs_clk;
   logic signed [15:0] i_phase_offset, o_applied_offset;
   logic [2:0] i_dpll_state_req, i_locked_damping, i_acquire_damping, i_apll_source_selector;
   logic [2:0] i_apll_alternate_selector, o_apll1_source, o_apll2_source;
   logic [3:0] i_locked_bandwidth, i_acquire_bandwidth, i_synth_measured_field_a_selector, o_eff_damping_x2, o_dpll_state;
   logic [3:0] o_synth_preset;
   logic signed [31:0] i_integral_path, i_master_clock_measured_field_a_trim, i_hold_measured_field_a_value, i_input_measured_field_a_offset;
   logic [31:0] i_hard_measured_field_a_limit, i_soft_measured_field_a_limit, i_input_measured_field_a_hard_limits, i_fb_remainder, i_fb_denominator;
   logic [31:0] o_fb_remainder_active, o_fb_denominator_active, r, seed, failures, checked, cycles;
   logic signed [9:0] i_phase_diff, o_measured_phase;
   logic signed [32:0] o_measured_field_a, o_nco_measured_field_a;
   logic [4:0] o_eff_bandwidth;
   logic [1:0] i_apll_input_divider, i_apll_enable_bit, o_apll_input_divider, o_apll_run, o_apll_relock;
   logic [15:0] i_synth_prog_mult, o_synth_mult_2khz;
   logic [5:0] i_high_speed_divider;
   logic [74:0] i_fb_integer_part, o_fb_integer_active, fbi;
   logic [6:0] i_fb_binary_point, o_fb_binary_point_active;

   dpll_apll_measured_field_a_config i_dpll_apll_measured_field_a_config (.*);

   // free-running 50 mhz clock plus a cycle ceiling so a hang still ends the run
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // outputs settle one edge after inputs, state-derived ones two, the switch pin three, so four is safe
   task automatic wt(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic report_and_stop();
      if (failures == 0 && checked != 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // expected apll source; the second apll reports crystal in dpll mode
   function automatic logic [2:0] src_exp(input logic one);
      logic [2:0] s;
      s = (i_pin_select_enable && i_ext_switch_pin) ? i_apll_alternate_selector : i_apll_source_selector;
      return s[2] ? (one ? 3'h4 : 3'h0) : {1'b0, s[1:0]};
   endfunction
   // frequency field as seen inside: wide mode doubles the lsb weight
   function automatic logic signed [32:0] sc(input logic [31:0] v, input logic w);
      return w ? {v, 1'b0} : {v[31], v};
   endfunction

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      seed = 32'h43C3A1BF; failures = 0; checked = 0; cycles = 0; i_reset_n = 1'b0;
      {i_phase_offset, i_integral_path, i_master_clock_measured_field_a_trim, i_hold_measured_field_a_value} = {$random(seed), 96'h0};
      {i_input_measured_field_a_offset, i_hard_measured_field_a_limit, i_soft_measured_field_a_limit, i_input_measured_field_a_hard_limits} = {96'h0, 32'h1000};
      {i_fb_remainder, i_fb_denominator, i_fb_integer_part, i_fb_binary_point} = {$random(seed), 114'h0};
      {i_wide_tracking_enable, i_ext_switch_pin, i_pin_select_enable, i_dpll_state_req} = 6'h00;
      {i_locked_damping, i_acquire_damping, i_apll_source_selector, i_apll_alternate_selector} = 12'h000;
      {i_locked_bandwidth, i_acquire_bandwidth, i_synth_measured_field_a_selector, i_phase_diff} = 22'h0;
      {i_apll_input_divider, i_apll_enable_bit, i_synth_prog_mult, i_high_speed_divider} = 26'h0;
      wt(8);
      i_reset_n <= 1'b1;
      wt(1);
      chk(o_dpll_state, 4'h1);
      chk(o_fb_binary_point_active, 7'h2A);
      // random source, synth and dpll state mixes, first pass forced to dpll via the pin
      for (int k = 0; k < 24; k++) begin
         @(posedge i_sys_clk);
         r = $random(seed);
         if (k == 0) {r[16:15], r[11:9]} = 5'h1C;
         {i_pin_select_enable, i_ext_switch_pin, i_apll_source_selector, i_apll_alternate_selector,
          i_synth_measured_field_a_selector, i_locked_bandwidth, i_wide_tracking_enable} <= r[16:0];
         i_dpll_state_req <= {1'b0, r[18:17]};
         {i_apll_input_divider, i_acquire_damping, i_synth_prog_mult} <= r[31:11];
         i_hold_measured_field_a_value <= $random(seed);
         i_integral_path <= $random(seed);
         i_input_measured_field_a_offset <= $random(seed) >>> 18;
         wt(4);
         chk(o_apll_input_divider, i_apll_input_divider);
         chk(o_synth_preset, (i_synth_measured_field_a_selector == 4'hF) ? 4'h0 : i_synth_measured_field_a_selector);
         chk(o_synth_mult_2khz, (i_synth_measured_field_a_selector == 4'hF) ? i_synth_prog_mult : 16'h0);
         chk(o_input_invalid, ((i_input_measured_field_a_offset < 0) ? -i_input_measured_field_a_offset : i_input_measured_field_a_offset) > 32'sh1000);
         if (i_dpll_state_req == 3'h3) chk(o_measured_field_a, sc(i_integral_path, i_wide_tracking_enable));
         if (i_dpll_state_req != 3'h3) chk(o_eff_damping_x2, {1'b0, i_acquire_damping} + i_wide_tracking_enable);
         chk(o_apll1_source, src_exp(1'b1));
         chk(o_apll2_source, src_exp(1'b0));
         chk(o_synth_programmable, i_synth_measured_field_a_selector == 4'hF);
         chk(o_dpll_state, 4'h1 << i_dpll_state_req);
         if (i_dpll_state_req == 3'h1) chk(o_nco_measured_field_a, sc(i_hold_measured_field_a_value, i_wide_tracking_enable));
         if (i_dpll_state_req == 3'h0) chk(o_nco_measured_field_a, 33'h0);
         if (i_dpll_state_req == 3'h3)
            chk(o_eff_bandwidth, {i_wide_tracking_enable ? {i_locked_bandwidth, 1'b0} : {1'b0, i_locked_bandwidth}});
      end
      // feedback fields load only on the enable rise, later writes wait
      @(posedge i_sys_clk);
      fbi = {11'h0, $random(seed), $random(seed)};
      i_fb_integer_part <= fbi;
      wt(1);
      i_apll_enable_bit <= 2'b01;
      wt(1);
      chk(o_apll_relock, 2'b01);
      chk(o_fb_integer_active, fbi);
      chk(o_fb_remainder_active, i_fb_remainder);
      chk(o_fb_denominator_active, i_fb_denominator);
      wt(1);
      chk(o_apll_relock, 2'b00);
      i_fb_integer_part <= ~fbi;
      wt(4);
      chk(o_fb_integer_active, fbi);
      chk(o_apll_run, 2'b01);
      i_apll_enable_bit <= 2'b00;
      wt(4);
      chk(o_apll_run, 2'b00);
      report_and_stop();
   end
endmodule
